// [verilog/spi_port_pkg.sv]
/*
  Shared constants and types for the serial register port: link timing,
  device register map, controller register offsets and state encodings.
  Assumes one 40 MHz clock in both ends and a byte-wide register space.
*/
package spi_port_pkg;

  // Clock and link timing
  localparam int MCLK_MHZ = 40;
  // Host serial clock half period, in ns and in cycles (rounded down)
  localparam int SCLK_HALF_NS = 200;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS * MCLK_MHZ) / 1000;
  // Longest reset duration of the device, in ns and cycles (rounded up)
  localparam int RESET_WAIT_NS = 100;
  localparam int RESET_WAIT_CYC = (RESET_WAIT_NS * MCLK_MHZ + 999) / 1000;

  ////////////////////////////////////////////////////////////////////////
  // Device register map
  localparam int ADDR_W = 7;
  localparam int REG_DEPTH = 128;
  localparam logic [6:0] CFG_A_ADDR = 7'h00;
  localparam logic [6:0] CFG_B_ADDR = 7'h01;
  localparam int STEP_HI_BIT = 5;
  localparam int STEP_LO_BIT = 2;
  localparam int SINGLE_BIT = 7;
  localparam logic [7:0] REG_RST = 8'h00;
  // Multibyte window: 14 two-byte registers, odd address is the high byte
  localparam logic [6:0] MB_FIRST = 7'h20;
  localparam logic [6:0] MB_LAST = 7'h3B;

  ////////////////////////////////////////////////////////////////////////
  // Controller registers on APB
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] TXD_OFS = 8'h04;
  localparam logic [7:0] RXD_OFS = 8'h08;
  localparam logic [7:0] STAT_OFS = 8'h0C;
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_RD_BIT = 1;
  localparam int CTRL_ADDR_LSB = 8;
  localparam int CTRL_LEN_LSB = 16;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;

  // State encodings
  typedef enum logic [2:0] {
    d_idle = 3'b001,
    d_instr = 3'b010,
    d_data = 3'b100
  } dev_state_t;

  typedef enum logic [3:0] {
    h_wait = 4'b0001,
    h_idle = 4'b0010,
    h_shift = 4'b0100,
    h_gap = 4'b1000
  } host_state_t;

endpackage : spi_port_pkg

// [verilog/spi_link_if.sv]
/*
  Four-wire serial link between the controller and the register port.
  Assumes the bench joins both modports; the data-out wire idles high.
*/
`timescale 1ns/1ps
interface spi_link_if;
  logic cs_n; // Frame select, active low
  logic sclk; // Serial clock, idles low
  logic mosi; // Controller to device data
  logic miso_out; // Device data drive value
  logic miso_oe; // Device drives data-out while high
  logic miso; // Resolved data-out wire

  // Pull-up stands in for the released wire
  assign miso = miso_oe ? miso_out : 1'b1;

  modport host (output cs_n, output sclk, output mosi, input miso);
  modport device (input cs_n, input sclk, input mosi, output miso_out, output miso_oe);
endinterface : spi_link_if

// [verilog/sync_bit.sv]
/*
  Two flip-flop synchroniser for a group of independent level inputs.
  Assumes each bit is a slow level; no bus coherency is promised.
*/
`timescale 1ns/1ps
module sync_bit #(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  // First stage, read only by the second
  logic [W-1:0] meta_q;

  // Two stages; reset loads zero, which matches the idle link except data-out, which idles high
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= '0;
      dout <= '0;
    end
    else
    begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule : sync_bit

// [verilog/spi_reg_port.sv]
/*
  Device end of the serial register port: instruction and data phases,
  streaming with address stepping, single instruction mode and paired
  multibyte registers over a 128-byte register array.
  Assumes the link pins are asynchronous to mclk and that the serial
  clock is slow enough for mclk to see every level (about 8 mclk each).
*/
// Notes on behaviour
// - Mode zero: sample rising, shift falling
// - Every field travels MSB first
// - Instruction: R/W bit, 7-bit address
// - High R/W reads, low writes
// - Instruction address is first accessed
// - Writes store bytes, reads drive contents
// - Early release in instruction: no effect
// - Release before first byte: no effect
// - Whole bytes commit, partial byte dropped
// - Streaming steps address after each byte
// - Step direction from config, decrementing default
// - Single mode: new instruction per phase
// - Single mode bit resets to zero
// - Master holds select through multibyte write
// - Master addresses high byte, decrementing
// - Fourteen two-byte registers are paired
// - Master waits out reset time
`timescale 1ns/1ps
module spi_reg_port (
  input wire logic mclk,
  input wire logic rst,
  spi_link_if.device link,
  output logic wr_pulse,
  output logic [6:0] wr_addr,
  output logic [7:0] wr_data,
  output logic step_up,
  output logic single_mode,
  output logic busy
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and edge finding

  // Synchronised select, clock and data
  logic s_cs; // Inverted select, so reset leaves it at the idle level
  wire logic s_cs_n = ~s_cs;
  logic s_sclk;
  logic s_mosi;
  // Previous synchronised clock for edge detection
  logic sclk_d_q;
  logic sclk_rise;
  logic sclk_fall;

  // All three pins cross from the link before any logic sees them
  sync_bit #(
    .W(3)
  ) u_sync (
    .mclk(mclk),
    .rst(rst),
    .din({~link.cs_n, link.sclk, link.mosi}),
    .dout({s_cs, s_sclk, s_mosi})
  );

  // Edge history of the serial clock
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      sclk_d_q <= 1'b0;
    else
      sclk_d_q <= s_sclk;
  end

  assign sclk_rise = s_sclk & ~sclk_d_q;
  assign sclk_fall = ~s_sclk & sclk_d_q;

  ////////////////////////////////////////////////////////////////////////
  // Serial state

  spi_port_pkg::dev_state_t state_q;
  // Bit position within the current byte
  logic [2:0] bit_cnt_q;
  // Receive shift register, seven bits held back
  logic [6:0] rx_sh_q;
  // Transaction is a read
  logic rd_q;
  // Current register address
  logic [6:0] addr_q;
  // Outgoing read byte
  logic [7:0] tx_sh_q;
  // Register array
  logic [7:0] mem_q [spi_port_pkg::REG_DEPTH];
  // Held high byte of a multibyte write
  logic [7:0] hold_q;
  logic hold_v_q;
  logic [6:0] hold_addr_q;

  logic [7:0] rx_byte;
  logic instr_done;
  logic byte_done;
  logic [6:0] addr_next;
  logic in_mb;
  logic mb_more;
  logic stay_data;

  // newest bit enters at the bottom
  assign rx_byte = {rx_sh_q, s_mosi};
  assign instr_done = (state_q == spi_port_pkg::d_instr) && sclk_rise && (bit_cnt_q == 3'd7);
  assign byte_done = (state_q == spi_port_pkg::d_data) && sclk_rise && (bit_cnt_q == 3'd7);

  assign addr_next = step_up ? (addr_q + 7'd1) : (addr_q - 7'd1);

  assign in_mb = (addr_q >= spi_port_pkg::MB_FIRST) && (addr_q <= spi_port_pkg::MB_LAST);
  // High byte done; the low byte of the pair must still follow
  assign mb_more = in_mb && addr_q[0];
  assign stay_data = ~single_mode || mb_more;

  // Frame sequencer; release of select always returns to idle
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= spi_port_pkg::d_idle;
      bit_cnt_q <= 3'd0;
      rx_sh_q <= 7'h00;
      rd_q <= 1'b0;
      addr_q <= 7'h00;
    end
    else if (s_cs_n)
    begin
      state_q <= spi_port_pkg::d_idle;
      bit_cnt_q <= 3'd0;
    end
    else
    begin
      if (sclk_rise)
      begin
        rx_sh_q <= rx_byte[6:0];
        bit_cnt_q <= bit_cnt_q + 3'd1;
      end
      case (state_q)
        spi_port_pkg::d_idle:
        begin
          state_q <= spi_port_pkg::d_instr;
          bit_cnt_q <= 3'd0;
        end
        spi_port_pkg::d_instr:
        begin
          if (instr_done)
          begin
            rd_q <= rx_byte[7];
            addr_q <= rx_byte[6:0];
            state_q <= spi_port_pkg::d_data;
          end
        end
        spi_port_pkg::d_data:
        begin
          if (byte_done)
          begin
            addr_q <= addr_next;
            if (!stay_data)
              state_q <= spi_port_pkg::d_instr;
          end
        end
        default:
          state_q <= spi_port_pkg::d_idle;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register array and write reporting

  // Committed bytes land here; a partial byte never reaches this process
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < spi_port_pkg::REG_DEPTH; i++)
        mem_q[i] <= spi_port_pkg::REG_RST;
      hold_q <= 8'h00;
      hold_v_q <= 1'b0;
      hold_addr_q <= 7'h00;
      wr_pulse <= 1'b0;
      wr_addr <= 7'h00;
      wr_data <= 8'h00;
    end
    else
    begin
      wr_pulse <= 1'b0;
      if (s_cs_n)
        hold_v_q <= 1'b0;
      if (byte_done && !rd_q)
      begin
        if (in_mb && addr_q[0])
        begin
          // High byte waits for its partner so the pair lands together
          hold_q <= rx_byte;
          hold_v_q <= 1'b1;
          hold_addr_q <= addr_q;
        end
        else if (in_mb)
        begin
          if (hold_v_q && (hold_addr_q == (addr_q + 7'd1)))
          begin
            mem_q[hold_addr_q] <= hold_q;
            mem_q[addr_q] <= rx_byte;
            wr_pulse <= 1'b1;
            wr_addr <= addr_q;
            wr_data <= rx_byte;
          end
          hold_v_q <= 1'b0;
        end
        else
        begin
          mem_q[addr_q] <= rx_byte;
          wr_pulse <= 1'b1;
          wr_addr <= addr_q;
          wr_data <= rx_byte;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data path

  // Loads on byte boundaries, shifts out on falling edges
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      tx_sh_q <= 8'h00;
      link.miso_out <= 1'b0;
    end
    else if (instr_done)
      tx_sh_q <= mem_q[rx_byte[6:0]];
    else if (byte_done)
      // Next byte is fetched ahead so its MSB is ready at the next fall
      tx_sh_q <= mem_q[addr_next];
    else if (sclk_fall && (state_q == spi_port_pkg::d_data) && rd_q && !s_cs_n)
    begin
      link.miso_out <= tx_sh_q[7];
      tx_sh_q <= {tx_sh_q[6:0], 1'b0};
    end
  end

  // Output drive only during a read data phase
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      link.miso_oe <= 1'b0;
    else
      link.miso_oe <= !s_cs_n && (state_q == spi_port_pkg::d_data) && rd_q;
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration outputs

  // Registered copies of the interface configuration
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      step_up <= 1'b0;
      single_mode <= 1'b0;
      busy <= 1'b0;
    end
    else
    begin
      step_up <= mem_q[spi_port_pkg::CFG_A_ADDR][spi_port_pkg::STEP_HI_BIT]
               | mem_q[spi_port_pkg::CFG_A_ADDR][spi_port_pkg::STEP_LO_BIT];
      single_mode <= mem_q[spi_port_pkg::CFG_B_ADDR][spi_port_pkg::SINGLE_BIT];
      busy <= !s_cs_n;
    end
  end

endmodule : spi_reg_port

// [verilog/spi_host_ctrl.sv]
/*
  Controller end: APB slave with its own registers that runs one framed
  transfer of an instruction plus one to four data bytes.
  Assumes APB on mclk and a device that samples on rising serial edges.
*/
`timescale 1ns/1ps
module spi_host_ctrl (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  spi_link_if.host link
);

  spi_port_pkg::host_state_t state_q;
  logic [3:0] div_q; // Half period and reset wait counter
  logic [5:0] bits_q; // Bits still to send
  logic [39:0] sh_q; // Outgoing instruction and data
  logic [31:0] txd_q; // Data to send, first byte in the top
  logic [31:0] rxd_q; // Received bits, newest at the bottom
  logic [1:0] len_q; // Byte count minus one
  logic rd_q;
  logic [6:0] addr_q;
  logic done_q; // Sticky completion flag
  logic s_miso;
  logic acc; // APB access completes this edge
  logic go;
  logic tick;

  sync_bit #(
    .W(1)
  ) u_sync (
    .mclk(mclk),
    .rst(rst),
    .din(link.miso),
    .dout(s_miso)
  );

  assign acc = psel && penable && pready;
  assign go = acc && pwrite && (paddr == spi_port_pkg::CTRL_OFS)
              && pwdata[spi_port_pkg::CTRL_GO_BIT];
  assign tick = div_q == 4'(spi_port_pkg::SCLK_HALF_CYC - 1);

  ////////////////////////////////////////////////////////////////////////
  // APB slave: one access cycle, read data registered at setup

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else if (psel && !penable)
    begin
      pready <= 1'b1;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      case (paddr)
        spi_port_pkg::CTRL_OFS: prdata <= {14'h0000, len_q, 1'b0, addr_q, 6'h00, rd_q, 1'b0};
        spi_port_pkg::TXD_OFS: prdata <= txd_q;
        spi_port_pkg::RXD_OFS: prdata <= rxd_q;
        spi_port_pkg::STAT_OFS: prdata <= {30'h0000_0000, done_q, state_q != spi_port_pkg::h_idle};
        default: pslverr <= 1'b1;
      endcase
    end
    else
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Software-written settings; ignored while a transfer runs
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      txd_q <= 32'h0000_0000;
      len_q <= 2'h0;
      rd_q <= 1'b0;
      addr_q <= 7'h00;
    end
    else if (acc && pwrite && (state_q == spi_port_pkg::h_idle))
    begin
      if (paddr == spi_port_pkg::TXD_OFS)
        txd_q <= pwdata;
      if (paddr == spi_port_pkg::CTRL_OFS)
      begin
        len_q <= pwdata[spi_port_pkg::CTRL_LEN_LSB +: 2];
        rd_q <= pwdata[spi_port_pkg::CTRL_RD_BIT];
        addr_q <= pwdata[spi_port_pkg::CTRL_ADDR_LSB +: 7];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Link sequencer

  // Clock divided from mclk; data changes on falls, sampled on rises
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= spi_port_pkg::h_wait;
      div_q <= 4'h0;
      bits_q <= 6'h00;
      sh_q <= 40'h00_0000_0000;
      rxd_q <= 32'h0000_0000;
      link.cs_n <= 1'b1;
      link.sclk <= 1'b0;
      link.mosi <= 1'b0;
    end
    else
    begin
      div_q <= tick ? 4'h0 : div_q + 4'h1;
      case (state_q)
        spi_port_pkg::h_wait:
          if (div_q == 4'(spi_port_pkg::RESET_WAIT_CYC))
            state_q <= spi_port_pkg::h_idle;
        spi_port_pkg::h_idle:
        begin
          div_q <= 4'h0;
          if (go && (state_q == spi_port_pkg::h_idle))
          begin
            sh_q <= {pwdata[spi_port_pkg::CTRL_RD_BIT],
                     pwdata[spi_port_pkg::CTRL_ADDR_LSB +: 7], txd_q};
            link.mosi <= pwdata[spi_port_pkg::CTRL_RD_BIT];
            bits_q <= {1'b0, pwdata[spi_port_pkg::CTRL_LEN_LSB +: 2], 3'b000} + 6'd16;
            link.cs_n <= 1'b0;
            state_q <= spi_port_pkg::h_shift;
          end
        end
        spi_port_pkg::h_shift:
          if (tick)
          begin
            if (!link.sclk)
            begin
              link.sclk <= 1'b1;
              rxd_q <= {rxd_q[30:0], s_miso};
              bits_q <= bits_q - 6'd1;
            end
            else
            begin
              link.sclk <= 1'b0;
              sh_q <= {sh_q[38:0], 1'b0};
              link.mosi <= sh_q[38];
              if (bits_q == 6'd0)
              begin
                link.cs_n <= 1'b1;
                state_q <= spi_port_pkg::h_gap;
              end
            end
          end
        spi_port_pkg::h_gap:
          if (tick)
            state_q <= spi_port_pkg::h_idle;
        default:
          state_q <= spi_port_pkg::h_idle;
      endcase
    end
  end

  // Done flag: the end of a frame wins over a clear in the same cycle
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      done_q <= 1'b0;
    else if ((state_q == spi_port_pkg::h_gap) && tick)
      done_q <= 1'b1;
    else if (acc && pwrite && (paddr == spi_port_pkg::STAT_OFS)
             && pwdata[spi_port_pkg::STAT_DONE_BIT])
      done_q <= 1'b0;
  end

endmodule : spi_host_ctrl

// [tb/spi_port_props.sv]
/*
  Checker for the serial link between the controller and the register port.
  Assumes the bench wires the link signals and device outputs by name.
*/
`timescale 1ns/1ps
module spi_port_props (
  input wire logic mclk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso_oe,
  input wire logic wr_pulse,
  input wire logic busy
);
  // One domain, all checks off in reset
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////
  // Steps of a frame
  sequence s_half_high;
    sclk [*8];
  endsequence
  sequence s_quiet_instr;
    !miso_oe [*8];
  endsequence

  property p_sclk_idle;
    cs_n |-> !sclk;
  endproperty
  a_sclk_idle: assert property (p_sclk_idle)
    else $error("serial clock high outside a frame");
  property p_half;
    $rose(sclk) |-> s_half_high ##1 !sclk;
  endproperty
  a_half: assert property (p_half)
    else $error("serial clock high phase not eight cycles");
  property p_mosi_hold;
    sclk |-> $stable(mosi);
  endproperty
  a_mosi_hold: assert property (p_mosi_hold)
    else $error("host data moved while clock high");
  property p_lead;
    $fell(cs_n) |-> !sclk [*4];
  endproperty
  a_lead: assert property (p_lead)
    else $error("clock rose too soon after select");
  property p_quiet;
    $fell(cs_n) |-> s_quiet_instr;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("device drove data during instruction");
  property p_busy;
    $fell(cs_n) |-> ##[1:5] busy;
  endproperty
  a_busy: assert property (p_busy)
    else $error("device missed frame start");
  property p_commit;
    wr_pulse |-> busy;
  endproperty
  a_commit: assert property (p_commit)
    else $error("write committed outside a frame");
  property p_byte_edge;
    wr_pulse |-> sclk;
  endproperty
  a_byte_edge: assert property (p_byte_edge)
    else $error("write not tied to a rising clock");
  property p_release;
    cs_n [*6] |-> !miso_oe;
  endproperty
  a_release: assert property (p_release)
    else $error("device still drives after release");
endmodule : spi_port_props

// [tb/dac_spi_register_port_tb.sv]
/*
  Bench: APB drives the controller, which frames the register port; a
  second port is driven bit by bit so frames can be cut short.
  Assumes both ends and the bench share one 40 MHz clock.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin \
    cmp_count++; \
    if ((g) !== (e)) \
    begin \
      miscompares++; \
      $display("[ERR] %s exp %h got %h", nm, e, g); \
    end \
  end
module dac_spi_register_port_tb;
  logic mclk, rst, psel, penable, pwrite, pready, pslverr, err, up;
  logic [7:0] paddr, b, d0, d1;
  logic [31:0] pwdata, prdata, rd, tx;
  logic wr_pulse, step_up, single_mode, busy, wr_pulse_b;
  logic [6:0] wr_addr, wr_addr_b;
  logic [7:0] wr_data, wr_data_b;
  logic [31:0] cap = 32'h0; // Bits seen on the host data line
  logic [15:0] expq[$]; // Expected {0, address, byte} per write
  int miscompares = 0, cmp_count = 0, cyc = 0, seed = 32'h86a6;

  // 40 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  spi_link_if lk ();
  spi_link_if lk2 ();
  spi_host_ctrl u_spi_host_ctrl (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(lk.host));
  spi_reg_port u_spi_reg_port (.mclk(mclk), .rst(rst), .link(lk.device), .wr_pulse(wr_pulse),
    .wr_addr(wr_addr), .wr_data(wr_data), .step_up(step_up), .single_mode(single_mode),
    .busy(busy));
  // Second port, framed by the bench to cut frames short
  spi_reg_port u_spi_reg_port_b (.mclk(mclk), .rst(rst), .link(lk2.device),
    .wr_pulse(wr_pulse_b), .wr_addr(wr_addr_b), .wr_data(wr_data_b), .step_up(),
    .single_mode(), .busy());
  spi_port_props u_spi_port_props (.mclk(mclk), .rst(rst), .cs_n(lk.cs_n), .sclk(lk.sclk),
    .mosi(lk.mosi), .miso_oe(lk.miso_oe), .wr_pulse(wr_pulse), .busy(busy));

  ////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test

  // Oldest note against a seen write; empty queue gives an impossible value
  task automatic pop_chk(input logic [15:0] g);
    logic [15:0] e;
    e = expq.size() ? expq.pop_front() : 16'hFFFF;
    `CHK("write", e, g)
  endtask : pop_chk

  // Write monitor and hang guard
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (wr_pulse === 1'b1)
      pop_chk({1'b0, wr_addr, wr_data});
    if (wr_pulse_b === 1'b1)
      pop_chk({1'b0, wr_addr_b, wr_data_b});
    // Limit well above the run length of some 7k cycles
    if (cyc == 60000)
    begin
      miscompares++;
      finish_test();
    end
  end

  // Host data line shifted on rising clock, cleared at frame start
  always @(posedge lk.sclk or negedge lk.cs_n)
    if (!lk.sclk)
      cap <= 32'h0;
    else
      cap <= {cap[30:0], lk.mosi};

  ////////////////////////////////////////////////////////////////////////
  // One APB transfer; read data and error taken at the ready edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // One framed transfer of n bytes; pe notes the stream writes first
  task automatic xfer(input logic r, input logic [6:0] a, input int n, input logic [31:0] t,
    input logic pe);
    if (pe && !r)
      for (int i = 0; i < n; i++)
        expq.push_back({1'b0, 7'(up ? a + i : a - i), t[31 - 8 * i -: 8]});
    apb(1'b1, spi_port_pkg::TXD_OFS, t);
    apb(1'b1, spi_port_pkg::CTRL_OFS, (32'(n - 1) << spi_port_pkg::CTRL_LEN_LSB) |
      (32'(a) << spi_port_pkg::CTRL_ADDR_LSB) | (32'(r) << spi_port_pkg::CTRL_RD_BIT) | 32'h1);
    rd = 32'h0;
    while (rd[spi_port_pkg::STAT_DONE_BIT] !== 1'b1)
      apb(1'b0, spi_port_pkg::STAT_OFS, 32'h0);
    apb(1'b1, spi_port_pkg::STAT_OFS, 32'h1 << spi_port_pkg::STAT_DONE_BIT);
    if (r)
      apb(1'b0, spi_port_pkg::RXD_OFS, 32'h0);
  endtask : xfer

  // Bench as master on the second link: n bits from bit 23 down, then release
  task automatic bang(input logic [23:0] v, input int n);
    lk2.cs_n <= 1'b0;
    repeat (4) @(posedge mclk);
    for (int i = 23; i > 23 - n; i--)
    begin
      lk2.mosi <= v[i];
      repeat (4) @(posedge mclk);
      lk2.sclk <= 1'b1;
      repeat (4) @(posedge mclk);
      lk2.sclk <= 1'b0;
    end
    repeat (4) @(posedge mclk);
    lk2.cs_n <= 1'b1;
    lk2.mosi <= ~v[24 - n];
    repeat (12) @(posedge mclk);
  endtask : bang

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    up = 1'b0;
    lk2.cs_n = 1'b1;
    lk2.sclk = 1'b0;
    lk2.mosi = 1'b0;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    // Longer than the reset time of the device
    repeat (10) @(posedge mclk);
    `CHK("step_up", 1'b0, step_up)
    `CHK("single_mode", 1'b0, single_mode)
    apb(1'b0, 8'h10, 32'h0);
    `CHK("pslverr", 1'b1, err)
    // Single write, wire order, read back
    b = 8'($random(seed));
    xfer(1'b0, 7'h05, 1, {b, 24'h0}, 1'b1);
    `CHK("wire", {1'b0, 7'h05, b}, cap[15:0])
    xfer(1'b1, 7'h05, 1, 32'h0, 1'b0);
    `CHK("read", b, rd[7:0])
    // Stream, decrementing by default
    tx = $random(seed);
    xfer(1'b0, 7'h12, 4, tx, 1'b1);
    xfer(1'b1, 7'h12, 4, 32'h0, 1'b0);
    `CHK("stream down", tx, rd)
    // Ascending from either step bit
    xfer(1'b0, spi_port_pkg::CFG_A_ADDR, 1, 32'h2000_0000, 1'b1);
    up = 1'b1;
    `CHK("step_up", 1'b1, step_up)
    tx = $random(seed);
    xfer(1'b0, 7'h40, 3, tx, 1'b1);
    xfer(1'b1, 7'h40, 3, 32'h0, 1'b0);
    `CHK("stream up", tx[31:8], rd[23:0])
    xfer(1'b0, spi_port_pkg::CFG_A_ADDR, 1, 32'h0400_0000, 1'b1);
    `CHK("step_up", 1'b1, step_up)
    xfer(1'b0, spi_port_pkg::CFG_A_ADDR, 1, 32'h0, 1'b1);
    up = 1'b0;
    // Lone high byte of a pair writes nothing
    // high byte first, step bits clear
    xfer(1'b0, 7'h21, 1, 32'hA500_0000, 1'b0);
    xfer(1'b1, 7'h21, 2, 32'h0, 1'b0);
    `CHK("lone high", 16'h0000, rd[15:0])
    tx = $random(seed);
    // Pair lands as one write, reported at the low byte
    expq.push_back({1'b0, 7'h22, tx[23:16]});
    xfer(1'b0, 7'h23, 2, tx, 1'b0);
    xfer(1'b1, 7'h23, 2, 32'h0, 1'b0);
    `CHK("pair", tx[31:16], rd[15:0])
    // Single instruction mode: second instruction in one frame
    xfer(1'b0, spi_port_pkg::CFG_B_ADDR, 1, 32'h8000_0000, 1'b1);
    `CHK("single_mode", 1'b1, single_mode)
    d0 = 8'($random(seed));
    d1 = 8'($random(seed));
    expq.push_back({1'b0, 7'h06, d0});
    expq.push_back({1'b0, 7'h07, d1});
    xfer(1'b0, 7'h06, 3, {d0, 8'h07, d1, 8'h00}, 1'b0);
    xfer(1'b1, 7'h07, 1, 32'h0, 1'b0);
    `CHK("single read", d1, rd[7:0])
    xfer(1'b0, spi_port_pkg::CFG_B_ADDR, 1, 32'h0, 1'b1);
    `CHK("single_mode", 1'b0, single_mode)
    // Cut frames: in instruction, within the first byte, after a byte
    b = 8'($random(seed));
    bang({8'h09, b, 8'hC3}, 5);
    bang({8'h09, b, 8'hC3}, 11);
    expq.push_back({1'b0, 7'h09, b});
    bang({8'h09, b, 8'hC3}, 21);
    repeat (20) @(posedge mclk);
    `CHK("pending", 32'h0, 32'(expq.size()))
    finish_test();
  end
endmodule : dac_spi_register_port_tb
